/* File: logic/gas_cmd_pkg.sv */
/*
  Shared constants, types and the checksum function for the gas sensor
  command block: command codes, execution times, response lengths,
  register offsets, reset values and interrupt bit positions.
  Assumes a 10 MHz pclk and an open-drain two-wire serial link.
*/
package gas_cmd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS         = 1000000;
  // Longest times round down to whole cycles
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int READY_MS      = 1;
  localparam int PERSIST_MS    = 800;
  localparam int SERIAL_MS     = 1;
  localparam int SELFTEST_MS   = 10000;

  ////////////////////////////////////////////////////////////////////////
  // Command codes and response lengths in bytes
  localparam logic [15:0] CODE_READY    = 16'hE4B8;
  localparam logic [15:0] CODE_PERSIST  = 16'h3615;
  localparam logic [15:0] CODE_SERIAL   = 16'h3682;
  localparam logic [15:0] CODE_SELFTEST = 16'h3639;
  localparam logic [3:0]  NB_NONE       = 4'h0;
  localparam logic [3:0]  NB_ONE_WORD   = 4'h3;
  localparam logic [3:0]  NB_SERIAL     = 4'h9;
  localparam logic [10:0] READY_FLAG    = 11'h001;

  // Link address, a plain default
  localparam logic [6:0]  DEV_ADDR_DEF  = 7'h2A;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] REG_CONFIG0  = 8'h00;
  localparam logic [7:0] REG_CONFIG1  = 8'h04;
  localparam logic [7:0] REG_RESULT   = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0C;
  localparam logic [7:0] REG_INT_STAT = 8'h10;
  localparam logic [7:0] REG_INT_MASK = 8'h14;
  localparam logic [7:0] REG_CAL_HIST = 8'h18;
  localparam logic [7:0] REG_SAVED0   = 8'h1C;
  localparam logic [7:0] REG_SAVED1   = 8'h20;
  localparam logic [7:0] REG_LAST_CMD = 8'h24;

  // Reset values
  localparam logic [31:0] CONFIG0_RST  = 32'h0000_0000;
  localparam logic        ABC_EN_RST   = 1'b1;
  localparam logic [3:0]  INT_MASK_RST = 4'h0;

  // Field positions
  localparam int CFG1_ABC_BIT   = 0;
  localparam int CFG1_FAULT_BIT = 8;
  localparam int RES_SET_BIT    = 0;
  localparam int RES_CLR_BIT    = 1;

  // Interrupt status bits
  localparam int INT_W         = 4;
  localparam int INT_DONE      = 0;
  localparam int INT_REFUSED   = 1;
  localparam int INT_UNKNOWN   = 2;
  localparam int INT_CAL_SAVED = 3;

  ////////////////////////////////////////////////////////////////////////
  // Nonvolatile store layout
  localparam int         NV_AW   = 2;
  localparam int         NV_DW   = 32;
  localparam logic [1:0] NV_CFG0 = 2'h0;
  localparam logic [1:0] NV_CFG1 = 2'h1;
  localparam logic [1:0] NV_CAL  = 2'h2;

  typedef struct packed {
    logic             we;
    logic [NV_AW-1:0] addr;
    logic [NV_DW-1:0] data;
  } nv_wr_s;

  ////////////////////////////////////////////////////////////////////////
  // States and commands
  typedef enum logic [6:0] {
    L_IDLE  = 7'h01,
    L_ADDR  = 7'h02,
    L_AACK  = 7'h04,
    L_WBYTE = 7'h08,
    L_WACK  = 7'h10,
    L_RBYTE = 7'h20,
    L_RACK  = 7'h40
  } link_state_e;

  typedef enum logic [4:0] {
    C_NONE     = 5'h01,
    C_READY    = 5'h02,
    C_PERSIST  = 5'h04,
    C_SERIAL   = 5'h08,
    C_SELFTEST = 5'h10
  } cmd_e;

  ////////////////////////////////////////////////////////////////////////
  // Checksum over one response word
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ w[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

endpackage

/* File: logic/sync2.sv */
/*
  Two-flop synchroniser for a bundle of slow levels.
  Assumes each bit changes far slower than the sampling clock.
*/
module sync2 #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0  // Idle level shown during reset
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* File: logic/nv_store.sv */
/*
  Small word store that models nonvolatile memory: contents are not
  touched by reset, read data leaves through a register.
  Assumes one write per cycle, offered as a packed write struct.
*/
module nv_store #(
  parameter int AW = gas_cmd_pkg::NV_AW,
  parameter int DW = gas_cmd_pkg::NV_DW
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Write port
  input  wire gas_cmd_pkg::nv_wr_s wr,
  // Read port
  input  wire logic [AW-1:0]       raddr,
  output logic      [DW-1:0]       rdata_q
);

  logic [DW-1:0] mem [2**AW];

  // Array is kept across reset, so it survives like a nonvolatile cell
  always_ff @(posedge clk) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.data;
    end
  end

  // Registered read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[raddr];
    end
  end

endmodule

/* File: logic/gas_sensor_cmd.sv */
/*
  Command interpreter for the status and advanced commands of a gas
  sensor: serial link target, command timer, response sender,
  configuration store and an APB register slave with interrupt.
  Assumes pclk at 10 MHz, SCL and SDA far slower, open-drain SDA.
*/
// Decided for this implementation: the register addresses and the APB register port.
// Contract
// - Readiness query finishes within 1 ms, one word, low 11 bits flag
// - Save command copies configuration to nonvolatile store within 800 ms
// - Configuration lives in volatile registers, lost at reset unless saved; the code never reloads the saved copy, reset restores defaults
// - Calibration history goes to nonvolatile store without any command
// - Identifier read returns three words, nine bytes, within 1 ms
// - Every response word is followed by its checksum byte
// - Self-test returns one checksummed status word within 10000 ms
// - Self-test word is zero when healthy, nonzero on malfunction
module gas_sensor_cmd #(
  parameter logic [6:0]  DEV_ADDR  = gas_cmd_pkg::DEV_ADDR_DEF,
  parameter int          MS_CYCLES = gas_cmd_pkg::MS_CYCLES_DEF,
  parameter logic [15:0] SERIAL_W0 = 16'h1357, // Arbitrary value
  parameter logic [15:0] SERIAL_W1 = 16'h2468, // Arbitrary value
  parameter logic [15:0] SERIAL_W2 = 16'hACE0  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // Link sampling
  logic [1:0] link_s;
  logic [1:0] link_p_q;
  logic       scl_s, sda_s, scl_p, sda_p;
  logic       scl_rise, scl_fall, bus_start, bus_stop;

  sync2 #(.W(2), .INIT(2'h3)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({scl_i, sda_i}),
    .q     (link_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_p_q <= 2'h3;
    end else begin
      link_p_q <= link_s;
    end
  end

  // Edges and bus conditions from synchronised levels
  assign {scl_s, sda_s} = link_s;
  assign {scl_p, sda_p} = link_p_q;
  assign scl_rise  = scl_s & ~scl_p;
  assign scl_fall  = ~scl_s & scl_p;
  assign bus_start = scl_s & scl_p & sda_p & ~sda_s;
  assign bus_stop  = scl_s & scl_p & ~sda_p & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Shared state declarations
  gas_cmd_pkg::link_state_e lst_q, lst_d;
  logic [7:0]  sh_q, sh_d, tx_q, tx_d, cmd_hi_q, cmd_hi_d;
  logic [3:0]  bit_q, bit_d, rd_idx_q, rd_idx_d;
  logic [1:0]  bcnt_q, bcnt_d;
  logic        oe_q, oe_d, rw_q, rw_d;
  logic        launch, refused;
  logic [15:0] launch_code;
  logic [7:0]  cur_byte;

  gas_cmd_pkg::cmd_e cmd_q, cmd_d;
  logic              busy_q, busy_d, done, unknown, tick, cal_taken;
  logic [13:0]       ms_q, ms_d;
  logic [23:0]       div_q, div_d;
  logic [2:0][15:0]  rsp_q, rsp_d;
  logic [3:0]        nb_q, nb_d;
  logic [1:0]        pw_q, pw_d;
  logic              cal_pend_q, cal_pend_d;
  logic [15:0]       wear_q, wear_d, last_q, last_d;
  gas_cmd_pkg::nv_wr_s nv_wr;

  logic [31:0] cfg0_q, cfg0_d, cal_q, cal_d;
  logic        abc_q, abc_d, fault_q, fault_d, newres_q, newres_d;
  logic        cal_wr;

  ////////////////////////////////////////////////////////////////////////
  // Response byte picked by read index: word high, word low, checksum
  logic [1:0]  wsel;
  logic [3:0]  part;
  always_comb begin
    wsel = (rd_idx_q >= 4'h6) ? 2'h2 : (rd_idx_q >= 4'h3) ? 2'h1 : 2'h0;
    part = rd_idx_q - ((wsel == 2'h2) ? 4'h6 : (wsel == 2'h1) ? 4'h3 : 4'h0);
    if (rd_idx_q >= nb_q) begin
      cur_byte = 8'hFF;
    end else if (part == 4'h0) begin
      cur_byte = rsp_q[wsel][15:8];
    end else if (part == 4'h1) begin
      cur_byte = rsp_q[wsel][7:0];
    end else begin
      cur_byte = gas_cmd_pkg::crc8(rsp_q[wsel]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link target state machine
  always_comb begin
    lst_d = lst_q; sh_d = sh_q; tx_d = tx_q; cmd_hi_d = cmd_hi_q;
    bit_d = bit_q; rd_idx_d = rd_idx_q; bcnt_d = bcnt_q;
    oe_d = oe_q; rw_d = rw_q;
    launch = 1'b0; refused = 1'b0;
    launch_code = {cmd_hi_q, sh_q};
    if (bus_start) begin
      lst_d = gas_cmd_pkg::L_ADDR; bit_d = 4'h0; oe_d = 1'b0;
    end else if (bus_stop) begin
      lst_d = gas_cmd_pkg::L_IDLE; oe_d = 1'b0;
    end else begin
      case (lst_q)
        gas_cmd_pkg::L_ADDR: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s}; bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_d = 4'h0; rw_d = sh_q[0];
            lst_d = gas_cmd_pkg::L_IDLE;
            if (sh_q[7:1] == DEV_ADDR) begin
              // Busy or empty response: leave the address unanswered
              if (busy_q || (sh_q[0] && nb_q == gas_cmd_pkg::NB_NONE)) begin
                refused = sh_q[0];
              end else begin
                oe_d = 1'b1; bcnt_d = 2'h0; rd_idx_d = 4'h0;
                lst_d = gas_cmd_pkg::L_AACK;
              end
            end
          end
        end
        gas_cmd_pkg::L_AACK: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rw_q) begin
              tx_d = cur_byte; oe_d = ~cur_byte[7];
              rd_idx_d = rd_idx_q + 4'h1;
              lst_d = gas_cmd_pkg::L_RBYTE;
            end else begin
              oe_d = 1'b0; lst_d = gas_cmd_pkg::L_WBYTE;
            end
          end
        end
        gas_cmd_pkg::L_WBYTE: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s}; bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_d = 4'h0; oe_d = 1'b1; lst_d = gas_cmd_pkg::L_WACK;
            if (bcnt_q == 2'h0) begin
              cmd_hi_d = sh_q;
            end
            launch = (bcnt_q == 2'h1);
            if (bcnt_q != 2'h3) begin
              bcnt_d = bcnt_q + 2'h1;
            end
          end
        end
        gas_cmd_pkg::L_WACK: begin
          if (scl_fall) begin
            oe_d = 1'b0; lst_d = gas_cmd_pkg::L_WBYTE;
          end
        end
        gas_cmd_pkg::L_RBYTE: begin
          if (scl_rise) begin
            bit_d = bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == 4'h8) begin
              oe_d = 1'b0; lst_d = gas_cmd_pkg::L_RACK;
            end else begin
              tx_d = {tx_q[6:0], 1'b0}; oe_d = ~tx_q[6];
            end
          end
        end
        gas_cmd_pkg::L_RACK: begin
          if (scl_rise) begin
            sh_d = {sh_q[7:1], sda_s};
          end else if (scl_fall) begin
            bit_d = 4'h0;
            if (!sh_q[0]) begin
              tx_d = cur_byte; oe_d = ~cur_byte[7];
              rd_idx_d = rd_idx_q + 4'h1;
              lst_d = gas_cmd_pkg::L_RBYTE;
            end else begin
              lst_d = gas_cmd_pkg::L_IDLE;
            end
          end
        end
        default: begin
          lst_d = gas_cmd_pkg::L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lst_q <= gas_cmd_pkg::L_IDLE; sh_q <= 8'h00; tx_q <= 8'h00;
      cmd_hi_q <= 8'h00; bit_q <= 4'h0; rd_idx_q <= 4'h0;
      bcnt_q <= 2'h0; oe_q <= 1'b0; rw_q <= 1'b0;
    end else begin
      lst_q <= lst_d; sh_q <= sh_d; tx_q <= tx_d;
      cmd_hi_q <= cmd_hi_d; bit_q <= bit_d; rd_idx_q <= rd_idx_d;
      bcnt_q <= bcnt_d; oe_q <= oe_d; rw_q <= rw_d;
    end
  end

  // Open drain: only ever pulls low
  assign sda_o  = 1'b0;
  assign sda_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Command execution timer, responses and nonvolatile writes
  assign tick = busy_q && (div_q == 24'(MS_CYCLES - 1));

  always_comb begin
    cmd_d = cmd_q; busy_d = busy_q; ms_d = ms_q; div_d = div_q;
    rsp_d = rsp_q; nb_d = nb_q; pw_d = pw_q; wear_d = wear_q;
    last_d = last_q; done = 1'b0; unknown = 1'b0; cal_taken = 1'b0;
    nv_wr = '0;
    if (launch) begin
      last_d = launch_code; nb_d = gas_cmd_pkg::NB_NONE; div_d = 24'h0;
      busy_d = 1'b1;
      case (launch_code)
        gas_cmd_pkg::CODE_READY: begin
          cmd_d = gas_cmd_pkg::C_READY;
          ms_d = 14'(gas_cmd_pkg::READY_MS);
        end
        gas_cmd_pkg::CODE_PERSIST: begin
          cmd_d = gas_cmd_pkg::C_PERSIST;
          ms_d = 14'(gas_cmd_pkg::PERSIST_MS);
        end
        gas_cmd_pkg::CODE_SERIAL: begin
          cmd_d = gas_cmd_pkg::C_SERIAL;
          ms_d = 14'(gas_cmd_pkg::SERIAL_MS);
        end
        gas_cmd_pkg::CODE_SELFTEST: begin
          cmd_d = gas_cmd_pkg::C_SELFTEST;
          ms_d = 14'(gas_cmd_pkg::SELFTEST_MS);
        end
        default: begin
          cmd_d = gas_cmd_pkg::C_NONE; busy_d = 1'b0; unknown = 1'b1;
        end
      endcase
    end else if (busy_q) begin
      div_d = tick ? 24'h0 : div_q + 24'h1;
      if (tick && ms_q == 14'h0001) begin
        busy_d = 1'b0; done = 1'b1;
        case (cmd_q)
          gas_cmd_pkg::C_READY: begin
            rsp_d[0] = {5'h00, newres_q ? gas_cmd_pkg::READY_FLAG
                                        : 11'h000};
            nb_d = gas_cmd_pkg::NB_ONE_WORD;
          end
          gas_cmd_pkg::C_PERSIST: begin
            pw_d = 2'h1;
          end
          gas_cmd_pkg::C_SERIAL: begin
            rsp_d = {SERIAL_W2, SERIAL_W1, SERIAL_W0};
            nb_d = gas_cmd_pkg::NB_SERIAL;
          end
          gas_cmd_pkg::C_SELFTEST: begin
            rsp_d[0] = {15'h0000, fault_q};
            nb_d = gas_cmd_pkg::NB_ONE_WORD;
          end
          default: begin
            nb_d = gas_cmd_pkg::NB_NONE;
          end
        endcase
      end else if (tick) begin
        ms_d = ms_q - 14'h0001;
      end
    end
    // Save takes the store first; calibration history waits its turn
    if (pw_q == 2'h1) begin
      nv_wr = '{we: 1'b1, addr: gas_cmd_pkg::NV_CFG0, data: cfg0_q};
      pw_d = 2'h2;
    end else if (pw_q == 2'h2) begin
      nv_wr = '{we: 1'b1, addr: gas_cmd_pkg::NV_CFG1,
                data: {23'h0, fault_q, 7'h00, abc_q}};
      pw_d = 2'h0; wear_d = wear_q + 16'h0001;
    end else if (cal_pend_q) begin
      nv_wr = '{we: 1'b1, addr: gas_cmd_pkg::NV_CAL, data: cal_q};
      cal_taken = 1'b1;
    end
    // A new history write in the same cycle keeps the request pending
    cal_pend_d = (cal_pend_q & ~cal_taken) | cal_wr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= gas_cmd_pkg::C_NONE; busy_q <= 1'b0; ms_q <= 14'h0000;
      div_q <= 24'h000000; rsp_q <= '0; nb_q <= 4'h0; pw_q <= 2'h0;
      cal_pend_q <= 1'b0; wear_q <= 16'h0000; last_q <= 16'h0000;
    end else begin
      cmd_q <= cmd_d; busy_q <= busy_d; ms_q <= ms_d;
      div_q <= div_d; rsp_q <= rsp_d; nb_q <= nb_d; pw_q <= pw_d;
      cal_pend_q <= cal_pend_d; wear_q <= wear_d; last_q <= last_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Nonvolatile store, read by the register slave
  logic [1:0]  nv_raddr;
  logic [31:0] nv_rdata;

  assign nv_raddr = (paddr == gas_cmd_pkg::REG_SAVED1)   ? gas_cmd_pkg::NV_CFG1 :
                    (paddr == gas_cmd_pkg::REG_CAL_HIST) ? gas_cmd_pkg::NV_CAL :
                    gas_cmd_pkg::NV_CFG0;

  nv_store u_nv (
    .clk     (pclk),
    .rst_n   (presetn),
    .wr      (nv_wr),
    .raddr   (nv_raddr),
    .rdata_q (nv_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB registers: one wait state, then pready for one cycle
  logic [3:0]  ist_q, ist_d, imask_q, imask_d, ev;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
  logic        acc, fire, wr_fire, rd_fire;

  assign acc     = psel & penable;
  assign fire    = acc & pready_q;
  assign wr_fire = fire & pwrite;
  assign rd_fire = fire & ~pwrite;
  assign ev      = {cal_taken, unknown, refused, done};

  always_comb begin
    cfg0_d = cfg0_q; abc_d = abc_q; fault_d = fault_q; cal_d = cal_q;
    imask_d = imask_q; prdata_d = prdata_q; pslverr_d = 1'b0;
    cal_wr = 1'b0;
    pready_d = acc & ~pready_q;
    if (acc && !pready_q) begin
      pslverr_d = 1'b0; prdata_d = 32'h0000_0000;
      case (paddr)
        gas_cmd_pkg::REG_CONFIG0:  prdata_d = cfg0_q;
        gas_cmd_pkg::REG_CONFIG1:  prdata_d = {23'h0, fault_q, 7'h00, abc_q};
        gas_cmd_pkg::REG_RESULT:   prdata_d = {31'h0, newres_q};
        gas_cmd_pkg::REG_STATUS:
          prdata_d = {wear_q, 8'h00, nb_q, 2'h0, (nb_q != 4'h0), busy_q};
        gas_cmd_pkg::REG_INT_STAT: prdata_d = {28'h0, ist_q};
        gas_cmd_pkg::REG_INT_MASK: prdata_d = {28'h0, imask_q};
        gas_cmd_pkg::REG_CAL_HIST: prdata_d = nv_rdata;
        gas_cmd_pkg::REG_SAVED0:   prdata_d = nv_rdata;
        gas_cmd_pkg::REG_SAVED1:   prdata_d = nv_rdata;
        gas_cmd_pkg::REG_LAST_CMD: prdata_d = {16'h0000, last_q};
        default:                   pslverr_d = 1'b1;
      endcase
    end
    if (wr_fire) begin
      case (paddr)
        gas_cmd_pkg::REG_CONFIG0:  cfg0_d = pwdata;
        gas_cmd_pkg::REG_CONFIG1: begin
          abc_d   = pwdata[gas_cmd_pkg::CFG1_ABC_BIT];
          fault_d = pwdata[gas_cmd_pkg::CFG1_FAULT_BIT];
        end
        gas_cmd_pkg::REG_INT_MASK: imask_d = pwdata[3:0];
        gas_cmd_pkg::REG_CAL_HIST: begin
          cal_d = pwdata; cal_wr = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Result flag: a set in the same write beats the clear
    newres_d = newres_q;
    if (wr_fire && paddr == gas_cmd_pkg::REG_RESULT) begin
      newres_d = (newres_q & ~pwdata[gas_cmd_pkg::RES_CLR_BIT])
               | pwdata[gas_cmd_pkg::RES_SET_BIT];
    end
    // Clear only the bits that were reported, so late events survive
    ist_d = ist_q;
    if (rd_fire && paddr == gas_cmd_pkg::REG_INT_STAT) begin
      ist_d = ist_q & ~prdata_q[3:0];
    end
    ist_d = ist_d | ev;
    irq_d = |(ist_d & imask_d);
  end

  // Volatile configuration returns to defaults on every reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0_q <= gas_cmd_pkg::CONFIG0_RST;
      abc_q <= gas_cmd_pkg::ABC_EN_RST; fault_q <= 1'b0;
      cal_q <= 32'h0000_0000; newres_q <= 1'b0;
      ist_q <= 4'h0; imask_q <= gas_cmd_pkg::INT_MASK_RST;
      prdata_q <= 32'h0000_0000; pready_q <= 1'b0;
      pslverr_q <= 1'b0; irq_q <= 1'b0;
    end else begin
      cfg0_q <= cfg0_d; abc_q <= abc_d; fault_q <= fault_d;
      cal_q <= cal_d; newres_q <= newres_d;
      ist_q <= ist_d; imask_q <= imask_d;
      prdata_q <= prdata_d; pready_q <= pready_d;
      pslverr_q <= pslverr_d; irq_q <= irq_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

endmodule

/* File: sim/gas_sensor_cmd_props.sv */
/*
  Checker on the command block ports: bus answer timing, refusals, pin.
  Assumes one pclk domain, presetn asynchronous and active low.
*/
module gas_sensor_cmd_props (
  // Clock, reset, bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Link
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Answer comes after exactly one wait state
  sequence s_first;
    psel && penable && !$past(penable);
  endsequence
  sequence s_wait;
    !pready ##1 pready;
  endsequence
  AST_ONE_WAIT: assert property (s_first |-> s_wait)
    else $error("late answer");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("long pready");
  AST_CAUSE: assert property (pready |-> psel && penable)
    else $error("stray pready");
  // Refusal only off the map, and it carries no data
  AST_ERR_RDY: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad refusal");
  AST_UNMAPPED: assert property (pready
    && (paddr > 8'h24 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped taken");
  AST_MAPPED: assert property (pready
    && paddr < 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped refused");
  // Open drain pin only pulls low, and moves while the link clock is low
  AST_SDA_LOW: assert property (!sda_o)
    else $error("sda driven high");
  AST_SDA_SCL: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda moved, scl high");
endmodule

bind gas_sensor_cmd gas_sensor_cmd_props P (.pclk, .presetn, .psel,
  .penable, .paddr, .prdata, .pready, .pslverr, .scl_i, .sda_o, .sda_oe);

/* File: sim/i2c_master_model.sv */
/*
  Link master: start, stop and 9-bit slots, 8 pclk (800 ns) per bit.
  Assumes SCL and SDA pulled up; clock stands high between frames.
*/
module i2c_master_model (
  // Clock and wire levels
  input  wire logic pclk,
  input  wire logic sda,
  output logic      scl,
  output logic      m_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus released at start
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  // Act just after a pclk edge
  task automatic t(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Low 6 cycles so the target can answer in time; sampled while high
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      t(3);
      m_oe <= !o[k];
      t(3);
      scl <= 1'b1;
      t(1);
      i[k] = sda;
      t(1);
      scl <= 1'b0;
    end
  endtask
  // Data edges while the clock is high frame the transfer
  task automatic start_c;
    t(1);
    m_oe <= 1'b1;
    t(4);
    scl <= 1'b0;
  endtask
  task automatic stop_c;
    t(3);
    m_oe <= 1'b1;
    t(3);
    scl <= 1'b1;
    t(3);
    m_oe <= 1'b0;
    t(4);
  endtask
endmodule

/* File: sim/gas_sensor_advanced_commands_test.sv */
/*
  Bench: bus and link calls with expected values for the command block.
  Assumes MS_CYCLES cut to 4 pclk; identifier words chosen for known checksums.
*/
module gas_sensor_advanced_commands_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, irq, sda_oe, scl, m_oe, se;
  int          err_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  wire         sda = !(sda_oe || m_oe);
  // Words whose checksums are known
  gas_sensor_cmd #(.MS_CYCLES(4), .SERIAL_W0(16'h0001),
    .SERIAL_W1(16'h8000), .SERIAL_W2(16'h0000)) DUT (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe, .irq);
  i2c_master_model M (.pclk, .sda, .scl, .m_oe);
  // Clock and hang guard
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      err_count++;
      finish_test;
    end
  end
  task automatic finish_test;
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [71:0] g, input logic [71:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t: got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic rst;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Bus word access; request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait out n ms of execution plus the frame tail
  task automatic wt(input int n);
    repeat (n * 4 + 20) @(posedge pclk);
  endtask
  task automatic cmd(input logic [15:0] c);
    logic [8:0] r;
    M.start_c;
    M.xfer({gas_cmd_pkg::DEV_ADDR_DEF, 2'b01}, r);
    M.xfer({c[15:8], 1'b1}, r);
    M.xfer({c[7:0], 1'b1}, r);
    chk(r[0], 0);
    M.stop_c;
  endtask
  // Read n bytes; n of 0 expects the address to be refused
  task automatic rd(input int n, input logic [71:0] e);
    logic [8:0]  r;
    logic [71:0] g;
    g = '0;
    M.start_c;
    M.xfer({gas_cmd_pkg::DEV_ADDR_DEF, 2'b11}, r);
    chk(r[0], n == 0);
    for (int k = 0; k < n; k++) begin
      M.xfer({8'hFF, k == n - 1}, r);
      g = {g[63:0], r[8:1]};
    end
    M.stop_c;
    chk(g, e);
  endtask
  // Main sequence
  initial begin
    rst;
    apb(1'b0, 8'h40, 32'h0);
    chk(se, 1);
    apb(1'b1, gas_cmd_pkg::REG_INT_MASK, 32'h1);
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, gas_cmd_pkg::REG_RESULT, f ? 32'h1 : 32'h2);
      apb(1'b1, gas_cmd_pkg::REG_CONFIG1, {23'h0, f[0], 8'h01});
      cmd(gas_cmd_pkg::CODE_READY);
      wt(gas_cmd_pkg::READY_MS);
      rd(3, f ? 24'h0001B0 : 24'h000081);
      cmd(gas_cmd_pkg::CODE_SELFTEST);
      rd(0, 0);
      wt(gas_cmd_pkg::SELFTEST_MS);
      rd(3, f ? 24'h0001B0 : 24'h000081);
    end
    cmd(gas_cmd_pkg::CODE_SERIAL);
    wt(gas_cmd_pkg::SERIAL_MS);
    rd(9, 72'h0001B0_8000A2_000081);
    chk(irq, 1);
    apb(1'b0, gas_cmd_pkg::REG_INT_STAT, 32'h0);
    chk(q[3:0], 4'h3);
    @(negedge pclk);
    chk(irq, 0);
    apb(1'b1, gas_cmd_pkg::REG_INT_MASK, 32'h0);
    apb(1'b1, gas_cmd_pkg::REG_CONFIG0, 32'h1234ABCD);
    cmd(gas_cmd_pkg::CODE_PERSIST);
    wt(gas_cmd_pkg::PERSIST_MS);
    chk(irq, 0);
    rd(0, 0);
    // Unknown code is ignored and reported
    cmd(16'h0000);
    apb(1'b0, gas_cmd_pkg::REG_INT_STAT, 32'h0);
    chk(q[2], 1'b1);
    apb(1'b1, gas_cmd_pkg::REG_CAL_HIST, 32'h5A5A0F0F);
    repeat (8) @(posedge pclk);
    rst;
    apb(1'b0, gas_cmd_pkg::REG_CONFIG0, 32'h0);
    chk(q, 0);
    apb(1'b0, gas_cmd_pkg::REG_SAVED0, 32'h0);
    chk(q, 32'h1234ABCD);
    apb(1'b0, gas_cmd_pkg::REG_CAL_HIST, 32'h0);
    chk(q, 32'h5A5A0F0F);
    finish_test;
  end
endmodule
